// ---- logic/au_top.sv ----
// Address generation datapath with four pointer sets and two transfer lanes
// Operation
// - Four pointer sets; pointer n always pairs with offset n and modifier n.
// - Indirect address is pointer; indexed adds offset; short mode adds immediate.
// - Modifier value selects update arithmetic and gives the modulus for modulo.
// - Linear, modulo and bit-reversed updates work in post/pre update and indexed modes; short mode adds linearly.
// - Linear updates are 16-bit two's complement sums wrapping at 65,536.
// - Linear addend is offset register, plus one, minus one or displacement.
// - Offset gives identical results read as signed or unsigned in linear updates; modulo takes bit 15 as the sign.
// - Modifier used by post/pre update and indexed modes; not others.
// - Two pointer sets per instruction, one per memory operation.
// - Second read of dual read updates pointer three ignoring its modifier.
// - Accumulator upper word serves as address without modifier update.
// - Up to two transfers per cycle, each with its own pointer update.
// - Mode picks operand place; two-word instructions take one extra cycle.
// - Bit-reversed post-increment by offset propagates carry from MSB downward.
`timescale 1ns/1ns
module au_top (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RSTN,
  // Register load from the decoder
  input  wire logic              LD_EN,
  input  wire au_pkg::au_load_e  LD_KIND,
  input  wire logic [1:0]        LD_IDX,
  input  wire logic [15:0]       LD_DATA,
  // First transfer lane
  input  wire logic              A_VALID,
  input  wire au_pkg::au_mode_e  A_MODE,
  input  wire logic [1:0]        A_SEL,
  input  wire logic [15:0]       A_DISP,
  // Second transfer lane
  input  wire logic              B_VALID,
  input  wire au_pkg::au_mode_e  B_MODE,
  input  wire logic [1:0]        B_SEL,
  input  wire logic [15:0]       B_DISP,
  input  wire logic              B_DUAL_READ,
  // Shared address sources
  input  wire logic [15:0]       PC,
  input  wire logic [15:0]       ACC_UPPER,
  input  wire logic              TWO_WORD,
  // Addresses out
  output logic      [15:0]       A_ADDR,
  output logic                   A_ADDR_VALID,
  output logic      [15:0]       B_ADDR,
  output logic                   B_ADDR_VALID,
  // Decoder hold for two-word instructions
  output logic                   EXEC_WAIT,
  // Pointer readback for the selected first-lane set
  output logic      [15:0]       A_PTR_VIEW
);
  logic [15:0] ptr_reg [au_pkg::NSETS];
  logic [15:0] off_reg [au_pkg::NSETS];
  logic [15:0] mod_reg [au_pkg::NSETS];

  // Per-lane mode decode
  function automatic logic uses_mod(input au_pkg::au_mode_e m);
    return (m == au_pkg::AM_POST_INC1) || (m == au_pkg::AM_POST_DEC1) ||
           (m == au_pkg::AM_POST_INC_OFF) || (m == au_pkg::AM_INDEXED_OFF) ||
           (m == au_pkg::AM_PRE_DEC1);
  endfunction

  function automatic logic writes_ptr(input au_pkg::au_mode_e m);
    return (m == au_pkg::AM_POST_INC1) || (m == au_pkg::AM_POST_DEC1) ||
           (m == au_pkg::AM_POST_INC_OFF) || (m == au_pkg::AM_PRE_DEC1);
  endfunction

  function automatic logic [15:0] pick_addend(input au_pkg::au_mode_e m,
                                              input logic [15:0] off,
                                              input logic [15:0] disp);
    logic [15:0] a;
    a = disp;
    if (m == au_pkg::AM_POST_INC1)
    begin
      a = au_pkg::ADD_ONE;
    end
    else if (m == au_pkg::AM_POST_DEC1 || m == au_pkg::AM_PRE_DEC1)
    begin
      a = au_pkg::ADD_MINUS;
    end
    else if (m == au_pkg::AM_POST_INC_OFF || m == au_pkg::AM_INDEXED_OFF)
    begin
      a = off;
    end
    return a;
  endfunction

  // Lane A operands
  wire logic [15:0] a_ptr    = ptr_reg[A_SEL];
  wire logic [15:0] a_addend = pick_addend(A_MODE, off_reg[A_SEL], A_DISP);
  // modifier only steers modes that use it
  wire logic        a_linear = !uses_mod(A_MODE);
  wire logic [15:0] a_calc;

  // Lane B operands
  wire logic [15:0] b_ptr    = ptr_reg[B_SEL];
  wire logic [15:0] b_addend = pick_addend(B_MODE, off_reg[B_SEL], B_DISP);
  // second dual read on pointer three skips its modifier
  wire logic        b_dual3  = B_DUAL_READ && (B_SEL == au_pkg::DUAL_PTR);
  wire logic        b_linear = !uses_mod(B_MODE) || b_dual3;
  wire logic [15:0] b_calc;

  // post/pre update and indexed modes go through the same lane; short displacement adds directly
  // reverse carry lives in the lane
  au_calc u_calc_a (
    .ptr         (a_ptr),
    .addend      (a_addend),
    .modifier    (mod_reg[A_SEL]),
    .linear_only (a_linear),
    .result      (a_calc)
  );

  // second set for the second memory operation
  au_calc u_calc_b (
    .ptr         (b_ptr),
    .addend      (b_addend),
    .modifier    (mod_reg[B_SEL]),
    .linear_only (b_linear),
    .result      (b_calc)
  );

  // Effective address per mode, one function for both lanes
  function automatic logic [15:0] pick_ea(input au_pkg::au_mode_e m,
                                          input logic [15:0] p,
                                          input logic [15:0] upd,
                                          input logic [15:0] disp,
                                          input logic [15:0] pc,
                                          input logic [15:0] acc);
    logic [15:0] e;
    e = p;
    // indexed and short displacement add to the pointer
    // pre-decrement uses the new value, post modes the old
    if (m == au_pkg::AM_INDEXED_OFF || m == au_pkg::AM_PRE_DEC1)
    begin
      e = upd;
    end
    else if (m == au_pkg::AM_SHORT_DISP)
    begin
      e = p + disp;
    end
    else if (m == au_pkg::AM_PC_REL)
    begin
      e = pc + disp;
    end
    else if (m == au_pkg::AM_ACC_UPPER)
    begin
      e = acc;
    end
    else if (m == au_pkg::AM_ABSOLUTE)
    begin
      e = disp;
    end
    return e;
  endfunction

  // mode picks register, memory or immediate source
  wire logic [15:0] a_ea = pick_ea(A_MODE, a_ptr, a_calc, A_DISP, PC, ACC_UPPER);
  wire logic [15:0] b_ea = pick_ea(B_MODE, b_ptr, b_calc, B_DISP, PC, ACC_UPPER);
  wire logic        a_go = A_VALID && (A_MODE != au_pkg::AM_NONE);
  wire logic        b_go = B_VALID && (B_MODE != au_pkg::AM_NONE);

  // both lanes write back in the same cycle
  wire logic        a_wr = a_go && writes_ptr(A_MODE);
  wire logic        b_wr = b_go && writes_ptr(B_MODE);

  // Register file; lane updates override a load, lane B last on a clash
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      for (int i = 0; i < au_pkg::NSETS; i++)
      begin
        ptr_reg[i] <= au_pkg::PTR_RESET;
        off_reg[i] <= au_pkg::OFF_RESET;
        mod_reg[i] <= au_pkg::MODF_RESET;
      end
    end
    else
    begin
      if (LD_EN && LD_KIND == au_pkg::LD_POINTER)
        ptr_reg[LD_IDX] <= LD_DATA;
      if (LD_EN && LD_KIND == au_pkg::LD_OFFSET)
        off_reg[LD_IDX] <= LD_DATA;
      if (LD_EN && LD_KIND == au_pkg::LD_MODIFIER)
        mod_reg[LD_IDX] <= LD_DATA;
      // wrapped linear result is stored as is
      // no sign handling needed on the offset
      if (a_wr)
        ptr_reg[A_SEL] <= a_calc;
      if (b_wr)
        ptr_reg[B_SEL] <= b_calc;
    end
  end

  // Registered addresses toward the memory buses
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      A_ADDR       <= au_pkg::PTR_RESET;
      B_ADDR       <= au_pkg::PTR_RESET;
      A_ADDR_VALID <= 1'h0;
      B_ADDR_VALID <= 1'h0;
      A_PTR_VIEW   <= au_pkg::PTR_RESET;
    end
    else
    begin
      A_ADDR       <= a_go ? a_ea : A_ADDR; // Hold last address when idle
      B_ADDR       <= b_go ? b_ea : B_ADDR;
      A_ADDR_VALID <= a_go;
      B_ADDR_VALID <= b_go;
      A_PTR_VIEW   <= ptr_reg[A_SEL];
    end
  end

  // one extra execution cycle for a two-word instruction
  logic [1:0] wait_reg;
  wire  logic [1:0] wait_next = TWO_WORD ? au_pkg::LONG_EXTRA
                              : (wait_reg != 2'h0) ? wait_reg - 2'h1 : 2'h0;

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      wait_reg <= 2'h0;
    else
      wait_reg <= wait_next;
  end

  assign EXEC_WAIT = (wait_reg != 2'h0);
endmodule

// ---- logic/au_pkg.sv ----
// Shared constants and types for the address unit
package au_pkg;
  // Datapath widths and pointer set count
  localparam int AW    = 16;
  localparam int NSETS = 4;
  localparam int IW    = 2;
  // Modifier codes; every other modifier value selects modulo (modulus = value + 1)
  localparam logic [15:0] MOD_LINEAR  = 16'hffff;
  localparam logic [15:0] MOD_BITREV  = 16'h0000;
  // Values after reset
  localparam logic [15:0] PTR_RESET   = 16'h0000;
  localparam logic [15:0] OFF_RESET   = 16'h0000;
  localparam logic [15:0] MODF_RESET  = 16'hffff;
  // Index of the pointer whose second dual-read update ignores its modifier
  localparam logic [1:0]  DUAL_PTR    = 2'h3;
  // Extra execution cycles for a two-word instruction
  localparam logic [1:0]  LONG_EXTRA  = 2'h1;
  // Constant addends
  localparam logic [15:0] ADD_ONE     = 16'h0001;
  localparam logic [15:0] ADD_MINUS   = 16'hffff;

  // Addressing modes presented by the decoder
  typedef enum logic [3:0] {
    AM_NONE,
    AM_NO_UPDATE,
    AM_POST_INC1,
    AM_POST_DEC1,
    AM_POST_INC_OFF,
    AM_INDEXED_OFF,
    AM_PRE_DEC1,
    AM_SHORT_DISP,
    AM_PC_REL,
    AM_ACC_UPPER,
    AM_ABSOLUTE
  } au_mode_e;

  // Target of a register load
  typedef enum logic [1:0] {
    LD_POINTER,
    LD_OFFSET,
    LD_MODIFIER
  } au_load_e;
endpackage

// ---- logic/au_calc.sv ----
// One address-arithmetic lane: linear, modulo and reverse-carry update
`timescale 1ns/1ns
module au_calc (
  // Operands
  input  wire logic [15:0] ptr,
  input  wire logic [15:0] addend,
  input  wire logic [15:0] modifier,
  // Force plain linear arithmetic
  input  wire logic        linear_only,
  // Result
  output logic      [15:0] result
);
  // Reverse the bit order of a word
  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction

  // Smear the modifier downward into a power-of-two block mask
  function automatic logic [15:0] smear(input logic [15:0] v);
    logic [15:0] m;
    m = v;
    m = m | (m >> 1);
    m = m | (m >> 2);
    m = m | (m >> 4);
    m = m | (m >> 8);
    return m;
  endfunction

  // Linear sum wraps at 16 bits on its own, signed or unsigned alike
  wire logic [15:0] lin_sum  = ptr + addend;
  // Reverse carry: add the mirrored operands, mirror back
  wire logic [15:0] rev_sum  = rev16(rev16(ptr) + rev16(addend));
  // Modulo window: block base, top and size
  wire logic [15:0] blk_mask = smear(modifier);
  wire logic [15:0] blk_base = ptr & ~blk_mask;
  wire logic [15:0] blk_top  = blk_base + modifier;
  wire logic [15:0] modulus  = modifier + au_pkg::ADD_ONE;
  wire logic        downward = addend[15];
  wire logic [15:0] mod_sum  = (!downward && (lin_sum > blk_top || lin_sum < blk_base))
                               ? lin_sum - modulus
                               : (downward && (lin_sum < blk_base || lin_sum > blk_top))
                               ? lin_sum + modulus
                               : lin_sum;

  // Modifier value picks the arithmetic kind
  wire logic is_linear = linear_only || (modifier == au_pkg::MOD_LINEAR);
  wire logic is_bitrev = !is_linear && (modifier == au_pkg::MOD_BITREV);

  assign result = is_linear ? lin_sum : (is_bitrev ? rev_sum : mod_sum);
endmodule

// ---- tb/au_monitor.sv ----
// Port checker for the address unit
`timescale 1ns/1ns
module au_monitor (
  // Clock and reset
  input wire logic             CLK,
  input wire logic             RSTN,
  // Requests
  input wire logic             A_VALID,
  input wire au_pkg::au_mode_e A_MODE,
  input wire logic [15:0]      A_DISP,
  input wire logic             B_VALID,
  input wire au_pkg::au_mode_e B_MODE,
  input wire logic [15:0]      B_DISP,
  input wire logic [15:0]      PC,
  input wire logic [15:0]      ACC_UPPER,
  input wire logic             TWO_WORD,
  // Results
  input wire logic [15:0]      A_ADDR,
  input wire logic             A_ADDR_VALID,
  input wire logic [15:0]      B_ADDR,
  input wire logic             B_ADDR_VALID,
  input wire logic             EXEC_WAIT,
  input wire logic [15:0]      A_PTR_VIEW
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Accepted requests; AM_NONE is ignored like an idle lane
  wire a_go = A_VALID && A_MODE != au_pkg::AM_NONE;
  wire b_go = B_VALID && B_MODE != au_pkg::AM_NONE;
  wire a_post = A_MODE inside {au_pkg::AM_NO_UPDATE, au_pkg::AM_POST_INC1,
                               au_pkg::AM_POST_DEC1, au_pkg::AM_POST_INC_OFF};
  a_pulse_a: assert property (a_go |=> A_ADDR_VALID)
    else $error("lane A address missing");
  a_idle_a: assert property (!a_go |=> !A_ADDR_VALID)
    else $error("lane A address without request");
  b_pulse_a: assert property (b_go |-> ##1 B_ADDR_VALID)
    else $error("lane B address missing");
  old_ptr_a: assert property (a_go && a_post |=> A_ADDR == A_PTR_VIEW)
    else $error("post mode address is not the old pointer");
  short_disp_a: assert property (a_go && A_MODE == au_pkg::AM_SHORT_DISP |=>
    A_ADDR == A_PTR_VIEW + $past(A_DISP)) else $error("short displacement sum wrong");
  acc_addr_a: assert property (a_go && A_MODE == au_pkg::AM_ACC_UPPER |=>
    A_ADDR == $past(ACC_UPPER)) else $error("accumulator address wrong");
  pc_rel_a: assert property (b_go && B_MODE == au_pkg::AM_PC_REL |=>
    B_ADDR == $past(PC) + $past(B_DISP)) else $error("relative address wrong");
  wait_set_a: assert property (TWO_WORD |=> EXEC_WAIT)
    else $error("extra cycle missing");
  wait_clr_a: assert property (!TWO_WORD |=> !EXEC_WAIT)
    else $error("extra cycle without long instruction");
  // Main scenarios reached
  cover property (a_go && b_go);
  cover property (TWO_WORD);
  cover property (a_go && A_MODE == au_pkg::AM_POST_INC_OFF);
endmodule

bind au_top au_monitor au_monitor_inst (.CLK, .RSTN, .A_VALID, .A_MODE, .A_DISP, .B_VALID,
  .B_MODE, .B_DISP, .PC, .ACC_UPPER, .TWO_WORD, .A_ADDR, .A_ADDR_VALID, .B_ADDR,
  .B_ADDR_VALID, .EXEC_WAIT, .A_PTR_VIEW);

// ---- tb/au_dec.sv ----
// Decoder model issuing loads and lane requests
`timescale 1ns/1ns
module au_dec (
  // Clock
  input  wire logic         CLK,
  // Register loads
  output logic              LD_EN,
  output au_pkg::au_load_e  LD_KIND,
  output logic [1:0]        LD_IDX,
  output logic [15:0]       LD_DATA,
  // Lanes
  output logic              A_VALID,
  output au_pkg::au_mode_e  A_MODE,
  output logic [1:0]        A_SEL,
  output logic [15:0]       A_DISP,
  output logic              B_VALID,
  output au_pkg::au_mode_e  B_MODE,
  output logic [1:0]        B_SEL,
  output logic [15:0]       B_DISP,
  // Shared sources
  output logic              B_DUAL_READ,
  output logic [15:0]       PC,
  output logic [15:0]       ACC_UPPER,
  output logic              TWO_WORD
);
  // Quiet decoder at time zero
  initial
  begin
    {LD_EN, A_VALID, B_VALID, B_DUAL_READ, TWO_WORD} = '0;
    {LD_IDX, A_SEL, B_SEL, LD_DATA, A_DISP, B_DISP, PC, ACC_UPPER} = '0;
    LD_KIND = au_pkg::LD_POINTER;
    A_MODE = au_pkg::AM_NONE;
    B_MODE = au_pkg::AM_NONE;
  end
  // One load, taken at the second edge
  task automatic ld(input au_pkg::au_load_e k, input logic [1:0] i, input logic [15:0] d);
    @(posedge CLK);
    LD_EN   <= 1'h1;
    LD_KIND <= k;
    LD_IDX  <= i;
    LD_DATA <= d;
    @(posedge CLK);
    LD_EN <= 1'h0;
  endtask
  // Both lanes for one cycle; a lane with AM_NONE stays idle
  task automatic op(input au_pkg::au_mode_e am, input logic [1:0] as, input logic [15:0] ad,
                    input au_pkg::au_mode_e bm, input logic [1:0] bs, input logic [15:0] bd);
    @(posedge CLK);
    A_VALID <= am != au_pkg::AM_NONE;
    B_VALID <= bm != au_pkg::AM_NONE;
    // Enum ports assigned one by one; a packed concatenation would need a cast
    A_MODE <= am;
    A_SEL  <= as;
    A_DISP <= ad;
    B_MODE <= bm;
    B_SEL  <= bs;
    B_DISP <= bd;
    @(posedge CLK);
    {A_VALID, B_VALID} <= 2'h0;
  endtask
  // Side inputs, held until changed
  task automatic aux(input logic dr, input logic [15:0] p, input logic [15:0] a, input logic t);
    {B_DUAL_READ, PC, ACC_UPPER, TWO_WORD} <= {dr, p, a, t};
  endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the address unit
`timescale 1ns/1ns
module tb;
  // Design signals
  logic             CLK, RSTN, LD_EN, A_VALID, B_VALID, B_DUAL_READ, TWO_WORD;
  logic             A_ADDR_VALID, B_ADDR_VALID, EXEC_WAIT;
  logic [1:0]       LD_IDX, A_SEL, B_SEL;
  logic [15:0]      LD_DATA, A_DISP, B_DISP, PC, ACC_UPPER, A_ADDR, B_ADDR, A_PTR_VIEW;
  au_pkg::au_load_e LD_KIND;
  au_pkg::au_mode_e A_MODE, B_MODE;
  int               failures, num_checks;

  au_top au_top_inst (.CLK, .RSTN, .LD_EN, .LD_KIND, .LD_IDX, .LD_DATA, .A_VALID, .A_MODE,
    .A_SEL, .A_DISP, .B_VALID, .B_MODE, .B_SEL, .B_DISP, .B_DUAL_READ, .PC, .ACC_UPPER,
    .TWO_WORD, .A_ADDR, .A_ADDR_VALID, .B_ADDR, .B_ADDR_VALID, .EXEC_WAIT, .A_PTR_VIEW);
  au_dec au_dec_inst (.CLK, .LD_EN, .LD_KIND, .LD_IDX, .LD_DATA, .A_VALID, .A_MODE, .A_SEL,
    .A_DISP, .B_VALID, .B_MODE, .B_SEL, .B_DISP, .B_DUAL_READ, .PC, .ACC_UPPER, .TWO_WORD);

  // 100 MHz clock
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Lane A alone; address is fixed one cycle after the request
  task automatic ra(input au_pkg::au_mode_e m, input logic [1:0] s, input logic [15:0] d,
                    input logic [15:0] ea);
    au_dec_inst.op(m, s, d, au_pkg::AM_NONE, 2'h0, 16'h0000);
    #1;
    chk(A_ADDR_VALID, 16'h0001);
    chk(A_ADDR, ea);
  endtask
  // Linear wrap, signed offset, pre and post modes on set 0
  task automatic t_linear();
    ra(au_pkg::AM_NO_UPDATE, 2'h0, 16'h0000, 16'h0000);
    au_dec_inst.ld(au_pkg::LD_POINTER, 2'h0, 16'hffff);
    au_dec_inst.ld(au_pkg::LD_OFFSET, 2'h0, 16'h8000);
    ra(au_pkg::AM_POST_INC1, 2'h0, 16'h0000, 16'hffff);
    ra(au_pkg::AM_POST_INC_OFF, 2'h0, 16'h0000, 16'h0000);
    ra(au_pkg::AM_POST_DEC1, 2'h0, 16'h0000, 16'h8000);
    ra(au_pkg::AM_PRE_DEC1, 2'h0, 16'h0000, 16'h7ffe);
    ra(au_pkg::AM_INDEXED_OFF, 2'h0, 16'h0000, 16'hfffe);
    ra(au_pkg::AM_NO_UPDATE, 2'h0, 16'h0000, 16'h7ffe);
    // Readback shows the pointer as it stood at the request edge
    chk(A_PTR_VIEW, 16'h7ffe);
  endtask
  // Reverse carry stepping by half of a 1024 point block
  task automatic t_bitrev();
    logic [15:0] e [6] = '{16'h0000, 16'h0200, 16'h0100, 16'h0300, 16'h0080, 16'h0280};
    au_dec_inst.ld(au_pkg::LD_MODIFIER, 2'h1, 16'h0000);
    au_dec_inst.ld(au_pkg::LD_OFFSET, 2'h1, 16'h0200);
    for (int i = 0; i < 6; i++)
      ra(au_pkg::AM_POST_INC_OFF, 2'h1, 16'h0000, e[i]);
  endtask
  // Modulus five wraps both ways; short displacement stays linear
  task automatic t_modulo();
    au_dec_inst.ld(au_pkg::LD_MODIFIER, 2'h2, 16'h0004);
    au_dec_inst.ld(au_pkg::LD_POINTER, 2'h2, 16'h0004);
    ra(au_pkg::AM_POST_INC1, 2'h2, 16'h0000, 16'h0004);
    ra(au_pkg::AM_POST_DEC1, 2'h2, 16'h0000, 16'h0000);
    ra(au_pkg::AM_NO_UPDATE, 2'h2, 16'h0000, 16'h0004);
    ra(au_pkg::AM_SHORT_DISP, 2'h2, 16'h0010, 16'h0014);
  endtask
  // Two lanes in one cycle; dual read ignores the reverse modifier of set 3
  task automatic t_dual();
    au_dec_inst.ld(au_pkg::LD_MODIFIER, 2'h3, 16'h0000);
    au_dec_inst.ld(au_pkg::LD_POINTER, 2'h3, 16'h0001);
    au_dec_inst.aux(1'h1, 16'h0000, 16'h0000, 1'h0);
    au_dec_inst.op(au_pkg::AM_POST_INC1, 2'h0, 16'h0000, au_pkg::AM_POST_INC1, 2'h3, 16'h0000);
    #1;
    chk(A_ADDR, 16'h7ffe);
    chk(B_ADDR, 16'h0001);
    chk(B_ADDR_VALID, 16'h0001);
    au_dec_inst.aux(1'h0, 16'h0000, 16'h0000, 1'h0);
    ra(au_pkg::AM_NO_UPDATE, 2'h0, 16'h0000, 16'h7fff);
    au_dec_inst.op(au_pkg::AM_NONE, 2'h0, 16'h0000, au_pkg::AM_NO_UPDATE, 2'h3, 16'h0000);
    #1;
    chk(B_ADDR, 16'h0002);
  endtask
  // Long instruction wait, accumulator, relative and absolute sources
  task automatic t_special();
    au_dec_inst.aux(1'h0, 16'hfff0, 16'h1234, 1'h1);
    @(posedge CLK);
    au_dec_inst.aux(1'h0, 16'hfff0, 16'h1234, 1'h0);
    #1;
    chk(EXEC_WAIT, 16'h0001);
    @(posedge CLK);
    #1;
    chk(EXEC_WAIT, 16'h0000);
    au_dec_inst.op(au_pkg::AM_ACC_UPPER, 2'h0, 16'h0000, au_pkg::AM_PC_REL, 2'h0, 16'h0020);
    #1;
    chk(A_ADDR, 16'h1234);
    chk(B_ADDR, 16'h0010);
    ra(au_pkg::AM_ABSOLUTE, 2'h0, 16'h4321, 16'h4321);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial
  begin
    failures = 0;
    num_checks = 0;
    RSTN = 1'b0;
    repeat (6) @(posedge CLK);
    RSTN <= 1'b1;
    t_linear();
    t_bitrev();
    t_modulo();
    t_dual();
    t_special();
    tally_and_finish();
  end
  // Cuts a hung run short
  initial
  begin
    #200000;
    failures++;
    tally_and_finish();
  end
endmodule
